// *** design/alu_pkg.sv ***
// constants, types and register map of the subtract/xor/swap execution block
package alu_pkg;
    localparam int DATA_W     = 8;
    localparam int FILE_DEPTH = 128;
    localparam int FADDR_W    = 7;
    localparam int BUS_W      = 32;
    localparam int OFF_W      = 12;

    // register byte offsets
    localparam logic [11:0] OFF_ACC    = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_CMD    = 12'h008;
    localparam logic [11:0] OFF_DIR_A  = 12'h00C;
    localparam logic [11:0] OFF_DIR_B  = 12'h010;
    localparam logic [11:0] OFF_DIR_C  = 12'h014;
    // file window 0x200..0x3FC, one byte per word
    localparam logic [2:0]  FILE_PAGE     = 3'h1;
    localparam int          FILE_PAGE_LSB = 9;
    localparam int          FILE_IDX_LSB  = 2;

    // load_direction_reg selectors
    localparam logic [6:0] DIR_SEL_A = 7'h05;
    localparam logic [6:0] DIR_SEL_B = 7'h06;
    localparam logic [6:0] DIR_SEL_C = 7'h07;

    localparam logic [7:0] DIR_RESET = 8'hFF;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic       DEST_ACC  = 1'b0;
    localparam logic       HRESP_OKAY = 1'b0;
    localparam int         HTRANS_ACTIVE_BIT = 1;

    typedef enum logic [2:0] {
        sub_acc_from_file,
        sub_acc_from_file_borrow,
        sub_acc_from_literal,
        xor_literal_into_acc,
        xor_acc_with_file,
        nibble_exchange,
        load_direction_reg,
        op_none
    } op_t;

    // command word, hwdata[18:0]
    typedef struct packed {
        logic [7:0] literal;
        logic [6:0] addr;
        logic       dest;
        op_t        op;
    } cmd_t;

    // status word, hwdata[2:0]
    typedef struct packed {
        logic zero;
        logic nibble_borrow_flag;
        logic carry;
    } flags_t;

    localparam int CMD_W   = $bits(cmd_t);
    localparam int FLAGS_W = $bits(flags_t);
    localparam flags_t FLAGS_RESET = 3'h0;
endpackage

// *** design/alu_core.sv ***
// combinational subtract, xor and nibble swap datapath
`timescale 1ns/1ps
module alu_core (
    // instruction
    input  wire alu_pkg::op_t op,
    input  wire logic         dest,
    // operands
    input  wire logic [7:0]   acc,
    input  wire logic [7:0]   file_val,
    input  wire logic [7:0]   literal,
    input  wire logic         carry_in,
    // results
    output logic [7:0]        result,
    output alu_pkg::flags_t   flags_out,
    output logic              upd_arith,
    output logic              upd_zero,
    output logic              to_acc,
    output logic              to_file
);
    wire       uses_lit = (op == alu_pkg::sub_acc_from_literal) || (op == alu_pkg::xor_literal_into_acc);
    wire       is_sub   = (op == alu_pkg::sub_acc_from_file) || (op == alu_pkg::sub_acc_from_file_borrow)
                       || (op == alu_pkg::sub_acc_from_literal);
    wire       is_xor   = (op == alu_pkg::xor_literal_into_acc) || (op == alu_pkg::xor_acc_with_file);
    wire [7:0] operand  = uses_lit ? literal : file_val;
    // borrow op feeds the carry in, plain subtract adds one
    wire       cin      = (op == alu_pkg::sub_acc_from_file_borrow) ? carry_in : 1'b1;   // [RL4]
    wire [8:0] diff     = {1'b0, operand} + {1'b0, ~acc} + 9'(cin);                       // [RL1] [RL8]
    wire [4:0] ldiff    = {1'b0, operand[3:0]} + {1'b0, ~acc[3:0]} + 5'(cin);             // [RL2]
    wire [7:0] swapped  = {file_val[3:0], file_val[7:4]};                                 // [RL6]
    wire       writes   = is_sub || is_xor || (op == alu_pkg::nibble_exchange);

    assign result    = is_sub ? diff[7:0] : (is_xor ? (acc ^ operand) : swapped);        // [RL5] [RL7]
    assign flags_out = '{zero: (result == 8'h00), nibble_borrow_flag: ldiff[4], carry: diff[8]}; // [RL9]
    assign upd_arith = is_sub;                                                            // [RL2]
    assign upd_zero  = is_sub || is_xor;                                                  // [RL5] [RL7]
    assign to_file   = writes && !uses_lit && (dest != alu_pkg::DEST_ACC);                // [RL1]
    assign to_acc    = writes && !to_file;
endmodule

// *** design/alu_exec.sv ***
// AHB-Lite slave that runs subtract/xor/swap/direction-load commands
// Contract
// RL1 - file minus accumulator, destination bit routes
// RL2 - carry and nibble borrow by greater-or-equal
// RL3 - operand 5..7 loads direction A/B/C
// RL4 - borrow subtract uses inverted carry flag
// RL5 - xor literal into accumulator, zero only
// RL6 - nibble swap, routed, flags untouched
// RL7 - xor with file 0..127, zero only
// RL8 - literal minus accumulator, same flags
// RL9 - zero flag set when result is zero
//
// Implementation choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module alu_exec #(
    parameter logic [7:0] DIR_INIT = alu_pkg::DIR_RESET
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // direction registers
    output logic [7:0]       port_a_direction,
    output logic [7:0]       port_b_direction,
    output logic [7:0]       port_c_direction
);
    function automatic logic is_file(input logic [11:0] a);
        return a[alu_pkg::FILE_PAGE_LSB +: 3] == alu_pkg::FILE_PAGE;
    endfunction

    function automatic logic [6:0] file_idx(input logic [11:0] a);
        return a[alu_pkg::FILE_IDX_LSB +: alu_pkg::FADDR_W];
    endfunction

    logic [7:0]      file_mem [alu_pkg::FILE_DEPTH];
    logic [7:0]      acc_reg;
    alu_pkg::flags_t flags_reg;
    logic [11:0]     addr_reg;
    logic            wr_pend_reg;
    logic            rd_pend_reg;
    logic            hreadyout_reg;
    logic [31:0]     hrdata_reg;
    logic            hresp_reg;
    logic [7:0]      dir_a_reg;
    logic [7:0]      dir_b_reg;
    logic [7:0]      dir_c_reg;
    logic [7:0]      acc_next;
    alu_pkg::flags_t flags_next;

    // address phase and decode
    wire             accept   = hsel && htrans[alu_pkg::HTRANS_ACTIVE_BIT] && hready;
    wire             hit_acc  = addr_reg == alu_pkg::OFF_ACC;
    wire             hit_stat = addr_reg == alu_pkg::OFF_STATUS;
    wire             hit_cmd  = addr_reg == alu_pkg::OFF_CMD;
    wire             hit_file = is_file(addr_reg);
    wire             sw_wr    = wr_pend_reg;
    wire             exec     = sw_wr && hit_cmd;
    alu_pkg::cmd_t   cmd;
    assign cmd = alu_pkg::cmd_t'(hwdata[alu_pkg::CMD_W-1:0]);

    // datapath
    wire [7:0]       file_rd  = file_mem[cmd.addr];
    wire [7:0]       alu_result;
    alu_pkg::flags_t alu_flags;
    wire             upd_arith;
    wire             upd_zero;
    wire             to_acc;
    wire             to_file;

    alu_core u_alu (
        .op        (cmd.op),
        .dest      (cmd.dest),
        .acc       (acc_reg),
        .file_val  (file_rd),
        .literal   (cmd.literal),
        .carry_in  (flags_reg.carry),
        .result    (alu_result),
        .flags_out (alu_flags),
        .upd_arith (upd_arith),
        .upd_zero  (upd_zero),
        .to_acc    (to_acc),
        .to_file   (to_file)
    );

    wire ld_dir  = exec && (cmd.op == alu_pkg::load_direction_reg);
    wire ld_a    = ld_dir && (cmd.addr == alu_pkg::DIR_SEL_A);                 // [RL3]
    wire ld_b    = ld_dir && (cmd.addr == alu_pkg::DIR_SEL_B);                 // [RL3]
    wire ld_c    = ld_dir && (cmd.addr == alu_pkg::DIR_SEL_C);                 // [RL3]
    wire fwr_exe = exec && to_file;                                            // [RL1] [RL6] [RL7]
    wire fwr_sw  = sw_wr && hit_file;

    assign acc_next = (exec && to_acc) ? alu_result :                          // [RL1] [RL5] [RL8]
                      (sw_wr && hit_acc) ? hwdata[7:0] : acc_reg;
    assign flags_next.carry = (exec && upd_arith) ? alu_flags.carry :          // [RL2] [RL4]
                              (sw_wr && hit_stat) ? hwdata[0] : flags_reg.carry;
    assign flags_next.nibble_borrow_flag = (exec && upd_arith) ? alu_flags.nibble_borrow_flag :  // [RL2]
                              (sw_wr && hit_stat) ? hwdata[1] : flags_reg.nibble_borrow_flag;
    assign flags_next.zero  = (exec && upd_zero) ? alu_flags.zero :            // [RL9]
                              (sw_wr && hit_stat) ? hwdata[2] : flags_reg.zero;

    // read mux, unmapped reads zero
    wire [31:0] rd_data = hit_acc  ? {24'h000000, acc_reg} :
                          hit_stat ? {29'h00000000, flags_reg} :
                          (addr_reg == alu_pkg::OFF_DIR_A) ? {24'h000000, dir_a_reg} :
                          (addr_reg == alu_pkg::OFF_DIR_B) ? {24'h000000, dir_b_reg} :
                          (addr_reg == alu_pkg::OFF_DIR_C) ? {24'h000000, dir_c_reg} :
                          hit_file ? {24'h000000, file_mem[file_idx(addr_reg)]} : 32'h00000000;

    // bus phases
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            addr_reg      <= 12'h000;
            wr_pend_reg   <= 1'b0;
            rd_pend_reg   <= 1'b0;
            hreadyout_reg <= 1'b1;
            hrdata_reg    <= 32'h00000000;
            hresp_reg     <= alu_pkg::HRESP_OKAY;
        end else begin
            if (accept) begin
                addr_reg <= haddr[alu_pkg::OFF_W-1:0];
            end
            wr_pend_reg   <= accept && hwrite;
            rd_pend_reg   <= accept && !hwrite;
            hreadyout_reg <= !(accept && !hwrite);
            if (rd_pend_reg) begin
                hrdata_reg <= rd_data;
            end
            hresp_reg     <= alu_pkg::HRESP_OKAY;
        end
    end

    // architectural state
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            acc_reg   <= alu_pkg::ACC_RESET;
            flags_reg <= alu_pkg::FLAGS_RESET;
            dir_a_reg <= DIR_INIT;
            dir_b_reg <= DIR_INIT;
            dir_c_reg <= DIR_INIT;
        end else begin
            acc_reg   <= acc_next;
            flags_reg <= flags_next;
            if (ld_a) begin
                dir_a_reg <= acc_reg;                                          // [RL3]
            end
            if (ld_b) begin
                dir_b_reg <= acc_reg;                                          // [RL3]
            end
            if (ld_c) begin
                dir_c_reg <= acc_reg;                                          // [RL3]
            end
        end
    end

    // file registers, no reset
    always_ff @(posedge clock) begin
        if (fwr_exe) begin
            file_mem[cmd.addr] <= alu_result;                                  // [RL1] [RL6] [RL7]
        end else if (fwr_sw) begin
            file_mem[file_idx(addr_reg)] <= hwdata[7:0];
        end
    end

    assign hreadyout        = hreadyout_reg;
    assign hrdata           = hrdata_reg;
    assign hresp            = hresp_reg;
    assign port_a_direction = dir_a_reg;
    assign port_b_direction = dir_b_reg;
    assign port_c_direction = dir_c_reg;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    wire x_sub   = exec && (cmd.op == alu_pkg::sub_acc_from_file);
    wire x_subb  = exec && (cmd.op == alu_pkg::sub_acc_from_file_borrow);
    wire x_subl  = exec && (cmd.op == alu_pkg::sub_acc_from_literal);
    wire x_xorl  = exec && (cmd.op == alu_pkg::xor_literal_into_acc);
    wire x_xorf  = exec && (cmd.op == alu_pkg::xor_acc_with_file);
    wire x_swap  = exec && (cmd.op == alu_pkg::nibble_exchange);
    wire [7:0] c_lit  = cmd.literal;
    wire       c_dest = cmd.dest;

    chk_sub_result: assert property (x_sub && !c_dest |=> // [RL1]
        acc_reg == 8'($past(file_rd) - $past(acc_reg))) else $error("file minus acc wrong");
    chk_sub_flags: assert property (x_sub |=> // [RL2]
        flags_reg.carry == ($past(acc_reg) <= $past(file_rd)) &&
        flags_reg.nibble_borrow_flag == ($past(acc_reg[3:0]) <= $past(file_rd[3:0])))
        else $error("subtract flags wrong");
    chk_dir_load: assert property (ld_a |=> // [RL3]
        port_a_direction == $past(acc_reg) && $stable(flags_reg)) else $error("direction load wrong");
    chk_borrow_sub: assert property (x_subb && !c_dest |=> // [RL4]
        acc_reg == 8'($past(file_rd) - $past(acc_reg) - 8'(!$past(flags_reg.carry))))
        else $error("borrow subtract wrong");
    chk_xor_lit: assert property (x_xorl |=> // [RL5]
        acc_reg == ($past(acc_reg) ^ $past(c_lit)) && $stable(flags_reg.carry)) else $error("xor literal wrong");
    chk_swap_acc: assert property (x_swap && !c_dest |=> // [RL6]
        acc_reg == {$past(file_rd[3:0]), $past(file_rd[7:4])} && $stable(flags_reg)) else $error("swap wrong");
    chk_xor_file: assert property (x_xorf && c_dest |=> // [RL7]
        $stable(acc_reg) && flags_reg.zero == (($past(acc_reg) ^ $past(file_rd)) == 8'h00))
        else $error("xor file wrong");
    chk_lit_sub: assert property (x_subl |=> // [RL8]
        acc_reg == 8'($past(c_lit) - $past(acc_reg)) && flags_reg.carry == ($past(acc_reg) <= $past(c_lit)))
        else $error("literal subtract wrong");
    chk_zero_flag: assert property (exec && upd_zero && to_acc |=> // [RL9]
        flags_reg.zero == (acc_reg == 8'h00)) else $error("zero flag wrong");
    chk_read_wait: assert property (accept && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    cov_sub_borrow: cover property (x_sub ##1 !flags_reg.carry);
    cov_swap_file:  cover property (x_swap && c_dest);
    cov_dir_c:      cover property (ld_c);
    cov_read_after: cover property (exec ##1 rd_pend_reg);
endmodule

// *** test/test_subtract_xor_swap_alu.sv ***
// self-checking bench for the subtract/xor/swap execution block
`timescale 1ns/1ps
module test_subtract_xor_swap_alu;
    logic        clock  = 1'b0;
    logic        reset  = 1'b1;
    logic        hsel   = 1'b0;
    logic [31:0] haddr  = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize  = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic [7:0]  port_a_direction;
    logic [7:0]  port_b_direction;
    logic [7:0]  port_c_direction;
    logic [7:0]  m_dir [3];
    int          bad_count  = 0;
    int          num_checks = 0;

    always #50 clock = ~clock;

    alu_exec alu_exec_i (
        .clock            (clock),
        .reset            (reset),
        .hsel             (hsel),
        .haddr            (haddr),
        .htrans           (htrans),
        .hwrite           (hwrite),
        .hsize            (hsize),
        .hwdata           (hwdata),
        .hready           (hreadyout),
        .hreadyout        (hreadyout),
        .hrdata           (hrdata),
        .hresp            (hresp),
        .port_a_direction (port_a_direction),
        .port_b_direction (port_b_direction),
        .port_c_direction (port_c_direction)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %08h expected %08h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (bad_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one single ahb transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clock);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, exp);
        check({31'h0, hresp}, 32'h0);
    endtask

    function automatic logic [31:0] faddr(input logic [6:0] n);
        return {22'h0, 1'b1, n, 2'b00};
    endfunction

    function automatic logic [31:0] reg_addr(input logic [11:0] off);
        return {20'h0, off};
    endfunction

    // expected result and flags of one command
    function automatic logic [10:0] expect_of(input alu_pkg::op_t op, input logic [7:0] a, input logic [7:0] f,
                                              input logic [7:0] k, input alu_pkg::flags_t fl);
        logic [7:0]      src;
        logic [7:0]      r;
        alu_pkg::flags_t o;
        src = (op == alu_pkg::sub_acc_from_literal) ? k : f;
        o   = fl;
        case (op)
            alu_pkg::sub_acc_from_file, alu_pkg::sub_acc_from_literal: begin
                r = src - a;
                o.carry = (a <= src);
                o.nibble_borrow_flag = (a[3:0] <= src[3:0]);
            end
            alu_pkg::sub_acc_from_file_borrow: begin
                r = f - a - 8'(!fl.carry);
                o.carry = ({1'b0, f} >= ({1'b0, a} + 9'(!fl.carry)));
                o.nibble_borrow_flag = ({1'b0, f[3:0]} >= ({1'b0, a[3:0]} + 5'(!fl.carry)));
            end
            alu_pkg::xor_literal_into_acc: r = a ^ k;
            alu_pkg::xor_acc_with_file: r = a ^ f;
            alu_pkg::nibble_exchange: r = {f[3:0], f[7:4]};
            default: r = a;
        endcase
        if (op <= alu_pkg::xor_acc_with_file) o.zero = (r == 8'h00);
        return {r, o};
    endfunction

    initial begin
        logic [7:0]      a;
        logic [7:0]      f;
        logic [7:0]      k;
        logic [6:0]      ad;
        logic            d;
        logic            to_file;
        logic [10:0]     e;
        alu_pkg::op_t    op;
        alu_pkg::flags_t fl;
        void'($urandom(17));
        m_dir = '{alu_pkg::DIR_RESET, alu_pkg::DIR_RESET, alu_pkg::DIR_RESET};
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        rd_chk(reg_addr(alu_pkg::OFF_ACC), 32'h0);
        rd_chk(reg_addr(alu_pkg::OFF_STATUS), 32'h0);
        wr(32'h0000_0018, 32'hFFFF_FFFF);
        rd_chk(32'h0000_0018, 32'h0);
        for (int i = 0; i < 300; i++) begin
            op = alu_pkg::op_t'(i % 8);
            a  = 8'($urandom);
            f  = 8'($urandom);
            k  = 8'($urandom);
            ad = 7'($urandom);
            d  = 1'($urandom);
            fl = alu_pkg::flags_t'(3'($urandom));
            if (i % 5 == 0) a = (op == alu_pkg::sub_acc_from_literal) ? k : f;
            if (i % 5 == 1) a = {f[7:4], f[3:0] + 4'h1};
            if (i % 11 == 0) ad = 7'h7F;
            if (op == alu_pkg::load_direction_reg) ad = 7'(4 + (i / 8) % 4);
            wr(reg_addr(alu_pkg::OFF_ACC), {24'h0, a});
            wr(reg_addr(alu_pkg::OFF_STATUS), {29'h0, fl});
            wr(faddr(ad), {24'h0, f});
            wr(reg_addr(alu_pkg::OFF_CMD), {13'h0, k, ad, d, op});
            e = expect_of(op, a, f, k, fl);
            to_file = d && (op <= alu_pkg::nibble_exchange) && (op != alu_pkg::sub_acc_from_literal)
                      && (op != alu_pkg::xor_literal_into_acc);
            if (op == alu_pkg::load_direction_reg && ad >= 7'h05) m_dir[ad - 7'h05] = a;
            rd_chk(reg_addr(alu_pkg::OFF_ACC), {24'h0, to_file ? a : e[10:3]});
            rd_chk(reg_addr(alu_pkg::OFF_STATUS), {29'h0, e[2:0]});
            rd_chk(faddr(ad), {24'h0, to_file ? e[10:3] : f});
            check({8'h0, port_a_direction, port_b_direction, port_c_direction},
                  {8'h0, m_dir[0], m_dir[1], m_dir[2]});
        end
        rd_chk(reg_addr(alu_pkg::OFF_DIR_C), {24'h0, m_dir[2]});
        reset <= 1'b1;
        @(posedge clock);
        reset <= 1'b0;
        check({8'h0, port_a_direction, port_b_direction, port_c_direction},
              {8'h0, {3{alu_pkg::DIR_RESET}}});
        rd_chk(reg_addr(alu_pkg::OFF_ACC), 32'h0);
        rd_chk(reg_addr(alu_pkg::OFF_STATUS), 32'h0);
        final_report();
    end

    initial begin
        #2_000_000;
        bad_count++;
        final_report();
    end
endmodule
